// ==== verilog/pipe_pkg.sv ====
// Purpose: Shared constants, tag type and field decoders for the fetch/dispatch pipeline.
// Assumes: Instruction words carry class, destination and source fields in their low bits.
// Notes: Bits above FIELDS_W of an instruction word pass through unexamined.
package pipe_pkg;
    // Cache block and fetch geometry
    localparam int BLOCK_INSNS = 8;
    localparam int PAIR_INSNS = 2;
    localparam int BLOCK_PAIRS = BLOCK_INSNS / PAIR_INSNS;
    localparam int FETCH_PAIRS_MAX = 2;
    localparam int IQ_PAIRS = 2;
    // Dispatch and execute resources
    localparam int DISPATCH_PAIRS = 2;
    localparam int DISPATCH_SLOTS = DISPATCH_PAIRS * PAIR_INSNS;
    localparam int INT_UNITS = 2;
    localparam int FP_ISSUE_MAX = 1;
    localparam int FP_STAGES = 3;
    // Instruction word fields
    localparam int REG_W = 5;
    localparam int FP_POS = 0;
    localparam int DST_LSB = 1;
    localparam int SRC_LSB = 6;
    localparam int FIELDS_W = SRC_LSB + REG_W;
    localparam int TAG_W = REG_W + 1;
    // Default sizes
    localparam int INSN_W_DEF = 16;
    localparam int ADDR_W_DEF = 30;
    localparam int CB_DEPTH_DEF = 16;
    localparam int RETIRE_W_DEF = 4;
    localparam logic [ADDR_W_DEF-1:0] FETCH_RESET_ADDR = 30'h0;

    typedef logic [TAG_W-1:0] tag_t;
    typedef logic [FIELDS_W-1:0] fields_t;

    // Class bit of an instruction
    function automatic logic is_fp(input fields_t w);
        return w[FP_POS];
    endfunction

    // Register tag written, split by register file
    function automatic tag_t dst_tag(input fields_t w);
        return {w[FP_POS], w[DST_LSB +: REG_W]};
    endfunction

    // Register tag read, same file as the class
    function automatic tag_t src_tag(input fields_t w);
        return {w[FP_POS], w[SRC_LSB +: REG_W]};
    endfunction
endpackage

// ==== verilog/iq_if.sv ====
// Purpose: Carrier between the fetcher's instruction queue and decode/dispatch.
// Assumes: Valid pairs form a prefix, oldest pair at index 0.
// Notes: take counts pairs leaving the queue in the current cycle.
`timescale 1ns/100ps
interface iq_if #(parameter int INSN_W = 16);
    logic [1:0] pair_valid;
    logic [2*INSN_W-1:0] pair [2];
    logic [1:0] take;
    modport fetch (output pair_valid, output pair, input take);
    modport decode (input pair_valid, input pair, output take);
endinterface

// ==== verilog/fetch_unit.sv ====
// Purpose: Fetch pointer, hit-path fetch of instruction pairs and the instruction queue.
// Assumes: Cache answers hit and block contents in the cycle of the request.
// Notes: On a miss the request simply stays up; line fill is handled elsewhere.
`timescale 1ns/100ps
module fetch_unit
    import pipe_pkg::*;
#(
    parameter int INSN_W = INSN_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_reload_busy,
    input wire logic i_cache_hit,
    input wire logic [BLOCK_INSNS*INSN_W-1:0] i_cache_block,
    input wire logic i_redirect,
    input wire logic [ADDR_W-1:0] i_redirect_addr,
    output logic o_fetch_req,
    output logic [ADDR_W-1:0] o_fetch_addr,
    iq_if.fetch q
);
    localparam int PI_W = $clog2(BLOCK_PAIRS);
    localparam int PW = PAIR_INSNS * INSN_W;

    logic [ADDR_W-1:0] fetch_ptr_reg;
    logic [PW-1:0] iq_reg [IQ_PAIRS];
    logic [PW-1:0] iq_next [IQ_PAIRS];
    logic [1:0] iq_cnt_reg;
    logic [1:0] iq_cnt_next;
    logic [PI_W-1:0] slot;
    int n_pairs;
    logic deliver;

    // Pairs available: bounded by block end, queue room and fetch width
    always_comb
    begin
        int left;
        int room;
        slot = fetch_ptr_reg[1 +: PI_W];
        left = BLOCK_PAIRS - int'(slot);
        room = IQ_PAIRS - int'(iq_cnt_reg) + int'(q.take);
        n_pairs = FETCH_PAIRS_MAX;
        if (left < n_pairs)
            n_pairs = left;
        if (room < n_pairs)
            n_pairs = room;
    end

    assign o_fetch_req = !i_reload_busy && !i_redirect && (n_pairs != 0);
    assign deliver = o_fetch_req && i_cache_hit;
    assign o_fetch_addr = fetch_ptr_reg;

    // Queue after this cycle: survivors shift down, hit pairs append
    always_comb
    begin
        int src;
        int k;
        src = 0;
        k = 0;
        iq_cnt_next = iq_cnt_reg - q.take;
        for (int j = 0; j < IQ_PAIRS; j++)
        begin
            src = j + int'(q.take);
            k = src - int'(iq_cnt_reg);
            iq_next[j] = '0;
            if (src < int'(iq_cnt_reg))
                iq_next[j] = iq_reg[src];
            else if (deliver && k < n_pairs)
            begin
                iq_next[j] = i_cache_block[(int'(slot) + k)*PW +: PW];
                iq_cnt_next = iq_cnt_next + 2'h1;
            end
        end
    end

    // Queue registers, loaded one edge after the hit request
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            iq_cnt_reg <= 2'h0;
            for (int j = 0; j < IQ_PAIRS; j++)
                iq_reg[j] <= '0;
        end
        else
        begin
            iq_cnt_reg <= iq_cnt_next;
            for (int j = 0; j < IQ_PAIRS; j++)
                iq_reg[j] <= iq_next[j];
        end
    end

    // Fetch pointer: sequential advance rolls into the next block
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            fetch_ptr_reg <= FETCH_RESET_ADDR[ADDR_W-1:0];
        else if (i_redirect)
            fetch_ptr_reg <= {i_redirect_addr[ADDR_W-1:1], 1'b0};
        else if (deliver)
            fetch_ptr_reg <= fetch_ptr_reg + ADDR_W'(n_pairs * PAIR_INSNS);
    end

    // Queue view toward decode
    always_comb
    begin
        for (int j = 0; j < IQ_PAIRS; j++)
        begin
            q.pair_valid[j] = (j < int'(iq_cnt_reg));
            q.pair[j] = iq_reg[j];
        end
    end
endmodule

// ==== verilog/pipe_ctrl.sv ====
// Purpose: Superscalar front/back-end timing: fetch, decode, in-order dispatch, execute, completion.
// Assumes: Single clock; hit path only; execution data paths live outside this block.
// Notes: Completion outputs are combinational strobes taken from completion-buffer flops.
// How it works
// - Hit instructions enter queue one cycle later
// - No fetch while a reload holds cache
// - Fetch pairs from one block, two pairs per cycle
// - Last block pair alone yields two instructions
// - Aligned block fetched in two four-wide cycles
// - Two integer dispatches, one per unit
// - One floating-point dispatch per cycle
// - Dispatch strictly in program order
// - Two dispatch pair positions; full holds decode
// - Floating-point pipe: three stages, one per cycle
// - Independent fp adds: three cycles, fully pipelined
// - Completion in order behind older fp work
// - Held integers complete with their fp
// - Integer completes the cycle after execute
// - Fp completes and writes back after stage three
// - Results forwarded from result buses to units
`timescale 1ns/100ps
module pipe_ctrl
    import pipe_pkg::*;
#(
    parameter int INSN_W = INSN_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int CB_DEPTH = CB_DEPTH_DEF,
    parameter int RETIRE_W = RETIRE_W_DEF
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_reload_busy,
    input wire logic i_cache_hit,
    input wire logic [BLOCK_INSNS*INSN_W-1:0] i_cache_block,
    input wire logic i_redirect,
    input wire logic [ADDR_W-1:0] i_redirect_addr,
    output logic o_fetch_req,
    output logic [ADDR_W-1:0] o_fetch_addr,
    output logic o_decode_stall,
    output logic [INT_UNITS-1:0] o_int_exec_valid,
    output logic [INT_UNITS-1:0] o_int_exec_fwd,
    output logic [FP_STAGES-1:0] o_fp_stage_valid,
    output logic o_fp_exec_fwd,
    output logic [RETIRE_W-1:0] o_complete_valid,
    output logic [RETIRE_W-1:0] o_complete_fp
);
    localparam int CBW = $clog2(CB_DEPTH);
    localparam int PW = PAIR_INSNS * INSN_W;
    localparam int NTAG = 2**TAG_W;

    // Parameter sanity
    if (INSN_W < FIELDS_W || CB_DEPTH < DISPATCH_SLOTS || (CB_DEPTH & (CB_DEPTH - 1)) != 0 || RETIRE_W < 1)
        $error("pipe_ctrl: unsupported parameter values");

    iq_if #(.INSN_W(INSN_W)) q();

    logic [INSN_W-1:0] disp_insn_reg [DISPATCH_SLOTS];
    logic [INSN_W-1:0] disp_insn_next [DISPATCH_SLOTS];
    logic [DISPATCH_SLOTS-1:0] disp_v_reg;
    logic [DISPATCH_SLOTS-1:0] disp_v_next;
    logic [DISPATCH_SLOTS-1:0] go;
    logic [DISPATCH_SLOTS-1:0] fwd;
    logic [CBW-1:0] slot_cb [DISPATCH_SLOTS];
    int int_sel [INT_UNITS];
    int n_int;
    int n_fp;
    int n_go;
    int fp_sel;
    logic [NTAG-1:0] busy_reg;
    logic [NTAG-1:0] bus_clear;
    logic [NTAG-1:0] disp_set;
    logic [INT_UNITS-1:0] int_v_reg;
    tag_t int_dst_reg [INT_UNITS];
    logic [CBW-1:0] int_cb_reg [INT_UNITS];
    logic [FP_STAGES-1:0] fp_v_reg;
    tag_t fp_dst_reg [FP_STAGES];
    logic [CBW-1:0] fp_cb_reg [FP_STAGES];
    logic fp_fwd_reg;
    logic [INT_UNITS-1:0] int_fwd_reg;
    logic [CB_DEPTH-1:0] cb_done_reg;
    logic [CB_DEPTH-1:0] cb_fp_reg;
    logic [CBW-1:0] cb_head_reg;
    logic [CBW-1:0] cb_tail_reg;
    logic [CBW:0] cb_cnt_reg;
    int n_ret;

    fetch_unit #(.INSN_W(INSN_W), .ADDR_W(ADDR_W)) u_fetch (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_reload_busy(i_reload_busy),
        .i_cache_hit(i_cache_hit),
        .i_cache_block(i_cache_block),
        .i_redirect(i_redirect),
        .i_redirect_addr(i_redirect_addr),
        .o_fetch_req(o_fetch_req),
        .o_fetch_addr(o_fetch_addr),
        .q(q.fetch)
    );

    // Result buses: integer units and the last fp stage free their tags
    always_comb
    begin
        bus_clear = '0;
        for (int k = 0; k < INT_UNITS; k++)
            if (int_v_reg[k])
                bus_clear[int_dst_reg[k]] = 1'b1;
        if (fp_v_reg[FP_STAGES-1])
            bus_clear[fp_dst_reg[FP_STAGES-1]] = 1'b1;
    end

    // Dispatch selection, oldest first, stopping at the first blocked slot
    always_comb
    begin
        logic stop;
        logic ok;
        logic [NTAG-1:0] pend;
        fields_t w;
        stop = 1'b0;
        ok = 1'b0;
        w = '0;
        pend = busy_reg & ~bus_clear;
        disp_set = '0;
        go = '0;
        fwd = '0;
        n_int = 0;
        n_fp = 0;
        n_go = 0;
        fp_sel = 0;
        for (int k = 0; k < INT_UNITS; k++)
            int_sel[k] = 0;
        for (int i = 0; i < DISPATCH_SLOTS; i++)
        begin
            slot_cb[i] = cb_tail_reg + CBW'(n_go);
            if (disp_v_reg[i] && !stop)
            begin
                w = disp_insn_reg[i][FIELDS_W-1:0];
                ok = is_fp(w) ? (n_fp < FP_ISSUE_MAX) : (n_int < INT_UNITS);
                ok = ok && !pend[src_tag(w)] && (n_go < CB_DEPTH - int'(cb_cnt_reg));
                if (ok)
                begin
                    go[i] = 1'b1;
                    fwd[i] = busy_reg[src_tag(w)];
                    pend[dst_tag(w)] = 1'b1;
                    disp_set[dst_tag(w)] = 1'b1;
                    if (is_fp(w))
                    begin
                        fp_sel = i;
                        n_fp = n_fp + 1;
                    end
                    else
                    begin
                        int_sel[n_int] = i;
                        n_int = n_int + 1;
                    end
                    n_go = n_go + 1;
                end
                else
                    stop = 1'b1;
            end
        end
    end

    // Pair positions: survivors compact forward, decoded pairs fill the rest
    always_comb
    begin
        int j;
        logic [1:0] keep;
        j = 0;
        keep = 2'b00;
        q.take = 2'h0;
        disp_v_next = '0;
        for (int i = 0; i < DISPATCH_SLOTS; i++)
            disp_insn_next[i] = '0;
        for (int p = 0; p < DISPATCH_PAIRS; p++)
        begin
            keep = disp_v_reg[2*p +: 2] & ~go[2*p +: 2];
            if (keep != 2'b00)
            begin
                disp_insn_next[2*j] = disp_insn_reg[2*p];
                disp_insn_next[2*j+1] = disp_insn_reg[2*p+1];
                disp_v_next[2*j +: 2] = keep;
                j = j + 1;
            end
        end
        for (int p = 0; p < IQ_PAIRS; p++)
        begin
            if (q.pair_valid[p] && j < DISPATCH_PAIRS)
            begin
                disp_insn_next[2*j] = q.pair[p][INSN_W-1:0];
                disp_insn_next[2*j+1] = q.pair[p][PW-1:INSN_W];
                disp_v_next[2*j +: 2] = 2'b11;
                q.take = q.take + 2'h1;
                j = j + 1;
            end
        end
    end

    assign o_decode_stall = q.pair_valid[0] && (q.take == 2'h0);

    // Dispatch positions
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            disp_v_reg <= '0;
            for (int i = 0; i < DISPATCH_SLOTS; i++)
                disp_insn_reg[i] <= '0;
        end
        else
        begin
            disp_v_reg <= disp_v_next;
            for (int i = 0; i < DISPATCH_SLOTS; i++)
                disp_insn_reg[i] <= disp_insn_next[i];
        end
    end

    // Busy tags: set at dispatch wins over a same-cycle bus clear
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            busy_reg <= '0;
        else
            busy_reg <= (busy_reg & ~bus_clear) | disp_set;
    end

    // Integer units: one execute cycle each
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            int_v_reg <= '0;
            int_fwd_reg <= '0;
            for (int k = 0; k < INT_UNITS; k++)
            begin
                int_dst_reg[k] <= '0;
                int_cb_reg[k] <= '0;
            end
        end
        else
        begin
            for (int k = 0; k < INT_UNITS; k++)
            begin
                int_v_reg[k] <= (k < n_int);
                int_fwd_reg[k] <= (k < n_int) && fwd[int_sel[k]];
                int_dst_reg[k] <= dst_tag(disp_insn_reg[int_sel[k]][FIELDS_W-1:0]);
                int_cb_reg[k] <= slot_cb[int_sel[k]];
            end
        end
    end

    // Floating-point pipe: advances every cycle, never stalls
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            fp_v_reg <= '0;
            fp_fwd_reg <= 1'b0;
            for (int s = 0; s < FP_STAGES; s++)
            begin
                fp_dst_reg[s] <= '0;
                fp_cb_reg[s] <= '0;
            end
        end
        else
        begin
            fp_v_reg <= {fp_v_reg[FP_STAGES-2:0], (n_fp != 0)};
            fp_fwd_reg <= (n_fp != 0) && fwd[fp_sel];
            fp_dst_reg[0] <= dst_tag(disp_insn_reg[fp_sel][FIELDS_W-1:0]);
            fp_cb_reg[0] <= slot_cb[fp_sel];
            for (int s = 1; s < FP_STAGES; s++)
            begin
                fp_dst_reg[s] <= fp_dst_reg[s-1];
                fp_cb_reg[s] <= fp_cb_reg[s-1];
            end
        end
    end

    // Completion: consecutive finished entries from the head
    always_comb
    begin
        logic stop;
        logic [CBW-1:0] idx;
        stop = 1'b0;
        idx = '0;
        n_ret = 0;
        o_complete_valid = '0;
        o_complete_fp = '0;
        for (int r = 0; r < RETIRE_W; r++)
        begin
            idx = cb_head_reg + CBW'(r);
            if (!stop && r < int'(cb_cnt_reg) && cb_done_reg[idx])
            begin
                o_complete_valid[r] = 1'b1;
                o_complete_fp[r] = cb_fp_reg[idx];
                n_ret = n_ret + 1;
            end
            else
                stop = 1'b1;
        end
    end

    // Completion buffer: allocate at dispatch, finish at end of execute
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cb_done_reg <= '0;
            cb_fp_reg <= '0;
            cb_head_reg <= '0;
            cb_tail_reg <= '0;
            cb_cnt_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < DISPATCH_SLOTS; i++)
                if (go[i])
                begin
                    cb_done_reg[slot_cb[i]] <= 1'b0;
                    cb_fp_reg[slot_cb[i]] <= is_fp(disp_insn_reg[i][FIELDS_W-1:0]);
                end
            for (int k = 0; k < INT_UNITS; k++)
                if (int_v_reg[k])
                    cb_done_reg[int_cb_reg[k]] <= 1'b1;
            if (fp_v_reg[FP_STAGES-1])
                cb_done_reg[fp_cb_reg[FP_STAGES-1]] <= 1'b1;
            cb_head_reg <= cb_head_reg + CBW'(n_ret);
            cb_tail_reg <= cb_tail_reg + CBW'(n_go);
            cb_cnt_reg <= cb_cnt_reg + (CBW+1)'(n_go) - (CBW+1)'(n_ret);
        end
    end

    assign o_int_exec_valid = int_v_reg;
    assign o_int_exec_fwd = int_fwd_reg;
    assign o_fp_stage_valid = fp_v_reg;
    assign o_fp_exec_fwd = fp_fwd_reg;
endmodule

// ==== test/pipe_ctrl_properties.sv ====
// Purpose: Port-level timing properties of pipe_ctrl.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Bound into every pipe_ctrl instance.
`timescale 1ns/100ps
module pipe_ctrl_checker
    import pipe_pkg::*;
#(
    parameter int INSN_W = INSN_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int RETIRE_W = RETIRE_W_DEF
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_reload_busy,
    input wire logic i_cache_hit,
    input wire logic [BLOCK_INSNS*INSN_W-1:0] i_cache_block,
    input wire logic i_redirect,
    input wire logic [ADDR_W-1:0] i_redirect_addr,
    input wire logic o_fetch_req,
    input wire logic [ADDR_W-1:0] o_fetch_addr,
    input wire logic o_decode_stall,
    input wire logic [INT_UNITS-1:0] o_int_exec_valid,
    input wire logic [INT_UNITS-1:0] o_int_exec_fwd,
    input wire logic [FP_STAGES-1:0] o_fp_stage_valid,
    input wire logic o_fp_exec_fwd,
    input wire logic [RETIRE_W-1:0] o_complete_valid,
    input wire logic [RETIRE_W-1:0] o_complete_fp
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    // Fetch side
    property p_reload_block;
        i_reload_busy |-> !o_fetch_req;
    endproperty
    property p_addr_stands;
        !(o_fetch_req && i_cache_hit) && !i_redirect |=> $stable(o_fetch_addr);
    endproperty
    property p_addr_step;
        o_fetch_req && i_cache_hit |=> (o_fetch_addr - $past(o_fetch_addr)) inside {2, 4};
    endproperty
    property p_last_pair;
        o_fetch_req && i_cache_hit && o_fetch_addr[2:1] == 2'b11
            |=> o_fetch_addr == {$past(o_fetch_addr[ADDR_W-1:3]) + 1'b1, 3'b000};
    endproperty
    // Execute and completion
    property p_fp_stages;
        o_fp_stage_valid[0] |=> o_fp_stage_valid[1] ##1 o_fp_stage_valid[2];
    endproperty
    property p_fp_complete;
        o_fp_stage_valid[2] |=> |(o_complete_valid & o_complete_fp);
    endproperty
    property p_prefix;
        (o_complete_valid & (o_complete_valid + 1'b1)) == '0;
    endproperty
    property p_one_fp_done;
        $countones(o_complete_fp & o_complete_valid) <= 1;
    endproperty
    property p_int_lane;
        o_int_exec_valid != 2'b10;
    endproperty
    property p_int_complete;
        |o_int_exec_valid && o_fp_stage_valid == 3'b000
            |=> $countones(o_complete_valid) >= $countones($past(o_int_exec_valid));
    endproperty
    property p_fwd_valid;
        (o_int_exec_fwd & ~o_int_exec_valid) == 2'b00 && (!o_fp_exec_fwd || o_fp_stage_valid[0]);
    endproperty

    a_reload_block: assert property (p_reload_block) else $error("fetch request during reload");
    a_addr_stands: assert property (p_addr_stands) else $error("fetch address moved");
    a_addr_step: assert property (p_addr_step) else $error("fetch address step wrong");
    a_last_pair: assert property (p_last_pair) else $error("last pair did not roll over");
    a_fp_stages: assert property (p_fp_stages) else $error("fp stage sequence broken");
    a_fp_complete: assert property (p_fp_complete) else $error("fp completion late");
    a_prefix: assert property (p_prefix) else $error("completion lanes not a prefix");
    a_one_fp_done: assert property (p_one_fp_done) else $error("two fp completions in a cycle");
    a_int_lane: assert property (p_int_lane) else $error("single integer not on unit zero");
    a_int_complete: assert property (p_int_complete) else $error("integer completion late");
    a_fwd_valid: assert property (p_fwd_valid) else $error("forward flag without execute");

    // Main scenarios reached
    c_four_done: cover property (&o_complete_valid);
    c_decode_stall: cover property (o_decode_stall);
    c_forward: cover property (|o_int_exec_fwd);
endmodule

bind pipe_ctrl pipe_ctrl_checker #(.INSN_W(INSN_W), .ADDR_W(ADDR_W), .RETIRE_W(RETIRE_W)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reload_busy(i_reload_busy), .i_cache_hit(i_cache_hit),
    .i_cache_block(i_cache_block), .i_redirect(i_redirect), .i_redirect_addr(i_redirect_addr),
    .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr), .o_decode_stall(o_decode_stall),
    .o_int_exec_valid(o_int_exec_valid), .o_int_exec_fwd(o_int_exec_fwd), .o_fp_stage_valid(o_fp_stage_valid),
    .o_fp_exec_fwd(o_fp_exec_fwd), .o_complete_valid(o_complete_valid), .o_complete_fp(o_complete_fp)
);

// ==== test/icache_model.sv ====
// Purpose: Instruction cache stand-in serving a program image.
// Assumes: Image holds two cache blocks; addresses at or above length miss.
// Notes: Slow mode hits only after a request has stood two cycles.
`timescale 1ns/100ps
module icache_model
    import pipe_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_fetch_req,
    input wire logic [ADDR_W_DEF-1:0] i_fetch_addr,
    input wire logic [2*BLOCK_INSNS*INSN_W_DEF-1:0] i_image,
    input wire logic [4:0] i_len,
    input wire logic i_slow,
    output logic o_hit,
    output logic [BLOCK_INSNS*INSN_W_DEF-1:0] o_block
);
    logic [1:0] wait_reg;
    logic [BLOCK_INSNS*INSN_W_DEF-1:0] line;

    // Cycles a missed request has waited
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            wait_reg <= 2'h0;
        else if (!i_fetch_req || o_hit)
            wait_reg <= 2'h0;
        else if (wait_reg != 2'h2)
            wait_reg <= wait_reg + 2'h1;
    end

    // Hit answer, garbage block on miss
    assign line = i_image[i_fetch_addr[3]*BLOCK_INSNS*INSN_W_DEF +: BLOCK_INSNS*INSN_W_DEF];
    assign o_hit = (i_fetch_addr < {25'h0, i_len}) && (!i_slow || wait_reg == 2'h2);
    assign o_block = o_hit ? line : ~line;
endmodule

// ==== test/pipe_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for pipe_ctrl.
// Assumes: Sources use register 31, which is never written, except instruction 1 of the dep program, which reads register 1.
// Notes: Row fields: program, cycle, addr, stall, int, fwd, fp, done, done fp.
`timescale 1ns/100ps
module pipe_ctrl_tb_top
    import pipe_pkg::*;
;
    typedef struct packed {logic [3:0] p, c, addr, stall, iv, ifw, fp, cv, cf;} row_s;
    localparam row_s ROWS [24] = '{
        36'h000000000, 36'h014000000, 36'h024000000, 36'h034030100, 36'h044000330, 36'h054000600,
        36'h064000411, 36'h074000011, 36'h124000000, 36'h134030100, 36'h144010200, 36'h154000400,
        36'h1640000f1, 36'h224000000, 36'h234000100, 36'h244030300, 36'h254000600, 36'h264000411,
        36'h274000071, 36'h328100000, 36'h434010000, 36'h444031010, 36'h454010030, 36'h464000010};
    localparam logic [7:0] FP_MASK [5] = '{8'h0c, 8'h01, 8'h03, 8'hff, 8'h00};

    logic i_ref_clk, i_rst_b, i_reload_busy, i_cache_hit, i_redirect, o_fetch_req, o_decode_stall, o_fp_exec_fwd;
    logic [BLOCK_INSNS*INSN_W_DEF-1:0] i_cache_block;
    logic [ADDR_W_DEF-1:0] i_redirect_addr, o_fetch_addr;
    logic [1:0] o_int_exec_valid, o_int_exec_fwd;
    logic [2:0] o_fp_stage_valid;
    logic [3:0] o_complete_valid, o_complete_fp;
    logic [2*BLOCK_INSNS*INSN_W_DEF-1:0] image;
    logic [4:0] prog_len;
    logic slow;
    int n_errors = 0, check_count = 0;

    // Clock at 50 MHz
    initial i_ref_clk = 1'b0;
    always #10 i_ref_clk = ~i_ref_clk;

    pipe_ctrl DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reload_busy(i_reload_busy),
        .i_cache_hit(i_cache_hit), .i_cache_block(i_cache_block), .i_redirect(i_redirect),
        .i_redirect_addr(i_redirect_addr), .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
        .o_decode_stall(o_decode_stall), .o_int_exec_valid(o_int_exec_valid), .o_int_exec_fwd(o_int_exec_fwd),
        .o_fp_stage_valid(o_fp_stage_valid), .o_fp_exec_fwd(o_fp_exec_fwd),
        .o_complete_valid(o_complete_valid), .o_complete_fp(o_complete_fp));

    icache_model u_cache (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_fetch_req(o_fetch_req),
        .i_fetch_addr(o_fetch_addr), .i_image(image), .i_len(prog_len), .i_slow(slow),
        .o_hit(i_cache_hit), .o_block(i_cache_block));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task conclude;
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Load program, hold reset 10 cycles
    task automatic start(input logic [7:0] mask, input logic [4:0] len, input logic slw, input logic dep);
        i_rst_b = 1'b0;
        i_reload_busy = 1'b0;
        i_redirect = 1'b0;
        i_redirect_addr = '0;
        slow = slw;
        prog_len = len;
        for (int i = 0; i < 16; i++)
            image[i*16 +: 16] = {5'h0, (dep && i == 1) ? 5'h01 : 5'h1f, 5'(i + 1), i < 8 ? mask[i] : 1'b0};
        repeat (10) @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h0);
        check(32'(o_fetch_req), 32'h1);
        check(32'(o_fp_stage_valid), 32'h0);
        check(32'(o_complete_valid), 32'h0);
        i_rst_b = 1'b1;
    endtask

    // Watchdog
    initial
    begin
        #50000;
        n_errors++;
        conclude();
    end

    initial
    begin
        // Table programs, at most one row per cycle
        for (int p = 0; p < 5; p++)
        begin
            start(FP_MASK[p], p == 3 ? 5'h08 : 5'h04, 1'b0, p == 4);
            for (int c = 0; c < 8; c++)
            begin
                #1;
                for (int r = 0; r < 24; r++)
                    if (ROWS[r].p == p && ROWS[r].c == c)
                    begin
                        check(32'(o_fetch_addr), 32'(ROWS[r].addr));
                        check(32'(o_decode_stall), 32'(ROWS[r].stall));
                        check(32'(o_int_exec_valid), 32'(ROWS[r].iv));
                        check(32'(o_int_exec_fwd), 32'(ROWS[r].ifw));
                        check(32'(o_fp_exec_fwd), 32'h0);
                        check(32'(o_fp_stage_valid), 32'(ROWS[r].fp));
                        check(32'(o_complete_valid), 32'(ROWS[r].cv));
                        check(32'(o_complete_fp), 32'(ROWS[r].cf));
                    end
                @(negedge i_ref_clk);
            end
        end
        // Aligned block, four per cycle, rolling on
        start(8'h00, 5'h10, 1'b0, 1'b0);
        @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h4);
        @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h8);
        // Redirect to odd address in final pair
        start(8'h00, 5'h10, 1'b0, 1'b0);
        i_redirect = 1'b1;
        i_redirect_addr = 30'h7;
        #2;
        check(32'(o_fetch_req), 32'h0);
        @(negedge i_ref_clk);
        i_redirect = 1'b0;
        check(32'(o_fetch_addr), 32'h6);
        @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h8);
        // Reload blocks the fetcher
        start(8'h00, 5'h10, 1'b0, 1'b0);
        i_reload_busy = 1'b1;
        #2;
        check(32'(o_fetch_req), 32'h0);
        repeat (3) @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h0);
        i_reload_busy = 1'b0;
        @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h4);
        // Slow cache: request stands
        start(8'h00, 5'h10, 1'b1, 1'b0);
        #2;
        check(32'(o_fetch_req), 32'h1);
        repeat (2) @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h0);
        @(negedge i_ref_clk);
        check(32'(o_fetch_addr), 32'h4);
        conclude();
    end
endmodule
